// file: src/rcs_reset_cause.sv
// Contract
// - plain registers power up unknown and keep contents across other resets
// - registers with reset state load per class: power, warm, or wake
// - watchdog or interrupt wake keeps registers; low PC becomes PC + 2
// - power-on: restart 0000h, mismatch, instr, timeout, powerdown set
// - brown-out: restart 0000h, those four set, brown-out clear, rest kept
// - reset instruction clears its flag; mismatch clears its flag
// - pin reset in run mode: restart 0000h, set timeout flag only
// - pin reset in idle or sleep: restart, set timeout, clear powerdown
// - pin reset at full power: restart, no flag changes
// - overflow with fault reset enabled: restart, set stack full flag
// - underflow with fault reset enabled: restart, set underflow flag
// - underflow with fault reset disabled: no restart, still set flag
// - watchdog at full power or run: restart 0000h, clear timeout
// - watchdog in idle or sleep: continue at PC + 2, clear both flags
// - interrupt wake: continue at PC + 2, clear powerdown flag
// - interrupt wake with global enable: load vector 0008h or 0018h
// - power class clears stack, PC, table regs; int regs ff, c0; bank 0
// - warm class as power but keeps stack flags, int bit 0, data regs
`timescale 1ns/100ps
`default_nettype none
`include "rcs_params.svh"

module rcs_reset_cause (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic por_event_i,
  input wire logic bor_event_i,
  input wire logic deep_sleep_wake_i,
  input wire logic config_mismatch_i,
  input wire logic reset_instr_i,
  input wire logic external_reset_pin_i,
  input wire logic stack_overflow_i,
  input wire logic stack_underflow_i,
  input wire logic watchdog_timer_i,
  input wire logic int_wake_i,
  input wire logic int_high_prio_i,
  input wire rcs_pkg::rcs_pm_t pm_mode_i,
  input wire logic stack_fault_reset_enable_i,
  input wire logic high_prio_global_int_enable_i,
  input wire logic low_prio_global_int_enable_i,
  input wire logic [`RCS_PC_W-1:0] pc_i,
  input wire logic cause_we_i,
  input wire logic [7:0] cause_wdata_i,
  input wire logic stack_flags_we_i,
  input wire logic [1:0] stack_flags_wdata_i,
  input wire logic retain_we_i,
  input wire logic [`RCS_RETAIN_AW-1:0] retain_waddr_i,
  input wire logic [7:0] retain_wdata_i,
  input wire logic [`RCS_RETAIN_AW-1:0] retain_raddr_i,
  output logic [7:0] reset_cause_register_o,
  output logic [7:0] stack_pointer_reg_o,
  output logic [`RCS_PC_W-1:0] top_of_stack_o,
  output logic [4:0] prog_counter_latch_upper_o,
  output logic [7:0] prog_counter_latch_high_o,
  output logic [21:0] table_pointer_o,
  output logic [7:0] table_latch_o,
  output logic [7:0] int_control_main_o,
  output logic [7:0] int_control_second_o,
  output logic [7:0] int_control_third_o,
  output logic [3:0] bank_select_reg_o,
  output logic core_restart_o,
  output logic pc_load_o,
  output logic [`RCS_PC_W-1:0] pc_load_value_o,
  output logic [7:0] retain_rdata_o
);
  import rcs_pkg::*;

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  // one event per cycle; power events outrank warm ones, wakes come last
  function automatic rcs_act_t rcs_pick(
    input logic por, input logic bor, input logic dsw, input logic cm,
    input logic ri, input logic pin, input logic sful, input logic sunf,
    input logic wdt, input logic iwk);
    rcs_act_t a;
    a = RCS_ACT_NONE;
    if (por) begin
      a = RCS_ACT_POR;
    end else if (bor) begin
      a = RCS_ACT_BOR;
    end else if (dsw) begin
      a = RCS_ACT_DSW;
    end else if (cm) begin
      a = RCS_ACT_CM;
    end else if (ri) begin
      a = RCS_ACT_RI;
    end else if (pin) begin
      a = RCS_ACT_PIN;
    end else if (sful) begin
      a = RCS_ACT_SFUL;
    end else if (sunf) begin
      a = RCS_ACT_SUNF;
    end else if (wdt) begin
      a = RCS_ACT_WDT;
    end else if (iwk) begin
      a = RCS_ACT_INT;
    end
    return a;
  endfunction

  function automatic logic [`RCS_PC_W-1:0] rcs_next_pc(
    input logic [`RCS_PC_W-1:0] pc);
    return pc + `RCS_PC_STEP;
  endfunction

  // core registers for a restart; power keeps nothing, warm keeps int bit 0
  function automatic rcs_state_t rcs_init_core(
    input rcs_state_t s, input logic power);
    rcs_state_t r;
    r = s;
    r.sp = `RCS_SP_RST;
    r.tos = `RCS_RESET_VECTOR;
    r.prog_counter_latch_upper = 5'h00;
    r.prog_counter_latch_high = 8'h00;
    r.tblptr = 22'h000000;
    r.table_latch = 8'h00;
    if (power) begin
      r.int_control_main = `RCS_INT_CONTROL_MAIN_RST;
    end else begin
      r.int_control_main = {7'h00, s.int_control_main[0]};
    end
    r.int_control_second = `RCS_INT_CONTROL_SECOND_RST;
    r.int_control_third = `RCS_INT_CONTROL_THIRD_RST;
    r.bank_select_reg = `RCS_BSR_RST;
    // priority enable bit reads 0 after every restart; wakes and stack errors with fault reset disabled keep it
    r.cause[`RCS_BIT_IPEN] = 1'b0;
    r.restart = 1'b1;
    r.pc_load = 1'b1;
    r.pc_val = `RCS_RESET_VECTOR;
    return r;
  endfunction

  // power-class state with the power-on cause pattern
  function automatic rcs_state_t rcs_power_state(input rcs_state_t s);
    rcs_state_t r;
    r = rcs_init_core(s, 1'b1);
    r.cause = `RCS_CAUSE_POR_VAL;
    r.stk_full = 1'b0;
    r.stk_unf = 1'b0;
    return r;
  endfunction

  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  rcs_state_t s_reg;
  rcs_state_t s_next;
  rcs_act_t act_w;
  logic idle_w;
  logic gie_w;

  assign act_w = rcs_pick(por_event_i, bor_event_i, deep_sleep_wake_i,
                          config_mismatch_i, reset_instr_i,
                          external_reset_pin_i, stack_overflow_i,
                          stack_underflow_i, watchdog_timer_i, int_wake_i);
  assign idle_w = (pm_mode_i == RCS_PM_IDLE);
  assign gie_w = high_prio_global_int_enable_i |
                 low_prio_global_int_enable_i;

  // --------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------
  // software writes first, events after: a hardware update wins a tie
  always_comb begin
    s_next = s_reg;
    s_next.restart = 1'b0;
    s_next.pc_load = 1'b0;
    if (cause_we_i) begin
      s_next.cause = cause_wdata_i & `RCS_CAUSE_MASK;
    end
    if (stack_flags_we_i) begin
      s_next.stk_full = stack_flags_wdata_i[1];
      s_next.stk_unf = stack_flags_wdata_i[0];
    end
    unique case (act_w)
      RCS_ACT_NONE: begin
        s_next.restart = 1'b0;
      end
      RCS_ACT_POR, RCS_ACT_DSW: begin
        s_next = rcs_power_state(s_next);
      end
      RCS_ACT_BOR: begin
        s_next = rcs_init_core(s_next, 1'b1);
        s_next.cause[`RCS_BIT_IPEN] = 1'b0;
        s_next.cause[`RCS_BIT_CM] = 1'b1;
        s_next.cause[`RCS_BIT_RI] = 1'b1;
        s_next.cause[`RCS_BIT_TO] = 1'b1;
        s_next.cause[`RCS_BIT_PD] = 1'b1;
        s_next.cause[`RCS_BIT_BOR] = 1'b0;
      end
      RCS_ACT_CM: begin
        s_next = rcs_init_core(s_next, 1'b0);
        s_next.cause[`RCS_BIT_CM] = 1'b0;
      end
      RCS_ACT_RI: begin
        s_next = rcs_init_core(s_next, 1'b0);
        s_next.cause[`RCS_BIT_RI] = 1'b0;
      end
      RCS_ACT_PIN: begin
        s_next = rcs_init_core(s_next, 1'b0);
        if (pm_mode_i != RCS_PM_FULL) begin
          s_next.cause[`RCS_BIT_TO] = 1'b1;
        end
        if (idle_w) begin
          s_next.cause[`RCS_BIT_PD] = 1'b0;
        end
      end
      RCS_ACT_SFUL: begin
        // a disabled fault reset still records the overflow
        if (stack_fault_reset_enable_i) begin
          s_next = rcs_init_core(s_next, 1'b0);
        end
        s_next.stk_full = 1'b1;
      end
      RCS_ACT_SUNF: begin
        if (stack_fault_reset_enable_i) begin
          s_next = rcs_init_core(s_next, 1'b0);
        end
        s_next.stk_unf = 1'b1;
      end
      RCS_ACT_WDT: begin
        if (idle_w) begin
          s_next.pc_load = 1'b1;
          s_next.pc_val = rcs_next_pc(pc_i);
          s_next.cause[`RCS_BIT_PD] = 1'b0;
        end else begin
          s_next = rcs_init_core(s_next, 1'b0);
        end
        s_next.cause[`RCS_BIT_TO] = 1'b0;
      end
      RCS_ACT_INT: begin
        s_next.pc_load = 1'b1;
        s_next.cause[`RCS_BIT_PD] = 1'b0;
        if (gie_w) begin
          // vectoring pushes the resume address
          s_next.tos = rcs_next_pc(pc_i);
          s_next.sp = s_reg.sp + `RCS_SP_STEP;
          s_next.pc_val = int_high_prio_i ? `RCS_VEC_HIGH
                                          : `RCS_VEC_LOW;
        end else begin
          s_next.pc_val = rcs_next_pc(pc_i);
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      s_reg <= rcs_power_state('0);
    end else begin
      s_reg <= s_next;
    end
  end

  // --------------------------------------------------------------------
  // retained data registers
  // --------------------------------------------------------------------
  rcs_retain_mem u_retain (
    .ref_clk_i(ref_clk_i),
    .we_i(retain_we_i),
    .waddr_i(retain_waddr_i),
    .wdata_i(retain_wdata_i),
    .raddr_i(retain_raddr_i),
    .rdata_o(retain_rdata_o)
  );

  // --------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------
  assign reset_cause_register_o = s_reg.cause;
  assign stack_pointer_reg_o = {s_reg.stk_full, s_reg.stk_unf, 1'b0,
                                s_reg.sp};
  assign top_of_stack_o = s_reg.tos;
  assign prog_counter_latch_upper_o = s_reg.prog_counter_latch_upper;
  assign prog_counter_latch_high_o = s_reg.prog_counter_latch_high;
  assign table_pointer_o = s_reg.tblptr;
  assign table_latch_o = s_reg.table_latch;
  assign int_control_main_o = s_reg.int_control_main;
  assign int_control_second_o = s_reg.int_control_second;
  assign int_control_third_o = s_reg.int_control_third;
  assign bank_select_reg_o = s_reg.bank_select_reg;
  assign core_restart_o = s_reg.restart;
  assign pc_load_o = s_reg.pc_load;
  assign pc_load_value_o = s_reg.pc_val;

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  a_por_pattern: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    act_w == RCS_ACT_POR |=> core_restart_o && pc_load_value_o == 21'h00000
      && reset_cause_register_o == 8'h3c
      && stack_pointer_reg_o == 8'h00)
    else $error("power-on cause pattern wrong");

  a_bor_flags: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    act_w == RCS_ACT_BOR && !stack_flags_we_i && !cause_we_i
      |=> reset_cause_register_o[5:2] == 4'hf
      && !reset_cause_register_o[0]
      && reset_cause_register_o[1] == $past(reset_cause_register_o[1])
      && stack_pointer_reg_o[7:6] == $past(stack_pointer_reg_o[7:6]))
    else $error("brown-out flags wrong");

  a_ri_clear: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    act_w == RCS_ACT_RI && !cause_we_i |=> core_restart_o
      && reset_cause_register_o ==
         ($past(reset_cause_register_o) & 8'h6f))
    else $error("reset instruction flag update wrong");

  a_pin_flags: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    act_w == RCS_ACT_PIN && pm_mode_i == RCS_PM_IDLE && !cause_we_i
      |=> reset_cause_register_o == (($past(reset_cause_register_o)
          | 8'h08) & 8'h7b))
    else $error("pin reset in sleep flags wrong");

  a_pin_full: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    act_w == RCS_ACT_PIN && pm_mode_i == RCS_PM_FULL && !cause_we_i
      |=> reset_cause_register_o[6:0] ==
          $past(reset_cause_register_o[6:0])
      && !reset_cause_register_o[7] && core_restart_o)
    else $error("pin reset at full power touched flags");

  a_unf_noreset: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    act_w == RCS_ACT_SUNF && !stack_fault_reset_enable_i
      |=> !core_restart_o && !pc_load_o && stack_pointer_reg_o[6])
    else $error("underflow without enable restarted");

  a_wdt_sleep: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    act_w == RCS_ACT_WDT && pm_mode_i == RCS_PM_IDLE
      |=> !core_restart_o && pc_load_o
      && pc_load_value_o == $past(pc_i) + 21'h00002
      && reset_cause_register_o[3:2] == 2'b00)
    else $error("watchdog wake from sleep wrong");

  a_int_vector: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    act_w == RCS_ACT_INT && gie_w
      |=> pc_load_o && pc_load_value_o ==
          ($past(int_high_prio_i) ? 21'h00008 : 21'h00018))
    else $error("interrupt vector wrong");

  a_warm_int_control_main: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    act_w == RCS_ACT_CM |=> int_control_second_o == 8'hff
      && int_control_third_o == 8'hc0
      && int_control_main_o == {7'h00, $past(int_control_main_o[0])}
      && bank_select_reg_o == 4'h0)
    else $error("warm reset core registers wrong");

  a_cause_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    act_w == RCS_ACT_NONE && !cause_we_i
      |=> $stable(reset_cause_register_o) && !core_restart_o)
    else $error("cause flags changed without event");

  c_power_on: cover property (@(posedge ref_clk_i) disable iff (rst_i)
    act_w == RCS_ACT_POR ##1 core_restart_o);
  c_int_vector: cover property (@(posedge ref_clk_i) disable iff (rst_i)
    act_w == RCS_ACT_INT && gie_w);
  c_wdt_wake: cover property (@(posedge ref_clk_i) disable iff (rst_i)
    act_w == RCS_ACT_WDT && idle_w);
  c_unf_error: cover property (@(posedge ref_clk_i) disable iff (rst_i)
    act_w == RCS_ACT_SUNF && !stack_fault_reset_enable_i);

endmodule // rcs_reset_cause

`default_nettype wire

// file: src/rcs_params.svh
`ifndef RCS_PARAMS_SVH
`define RCS_PARAMS_SVH

// ----------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------
`define RCS_PC_W 21
`define RCS_RETAIN_AW 3

// ----------------------------------------------------------------------
// program counter targets
// ----------------------------------------------------------------------
`define RCS_RESET_VECTOR 21'h00000
`define RCS_VEC_HIGH 21'h00008
`define RCS_VEC_LOW 21'h00018
`define RCS_PC_STEP 21'h00002

// ----------------------------------------------------------------------
// reset cause register fields and values
// ----------------------------------------------------------------------
`define RCS_BIT_IPEN 7
`define RCS_BIT_CM 5
`define RCS_BIT_RI 4
`define RCS_BIT_TO 3
`define RCS_BIT_PD 2
`define RCS_BIT_POR 1
`define RCS_BIT_BOR 0
`define RCS_CAUSE_MASK 8'hbf
`define RCS_CAUSE_POR_VAL 8'h3c

// ----------------------------------------------------------------------
// stack pointer register fields
// ----------------------------------------------------------------------
`define RCS_BIT_STACK_FULL_FLAG 7
`define RCS_BIT_STACK_UNDERFLOW_FLAG 6
`define RCS_SP_RST 5'h00
`define RCS_SP_STEP 5'h01

// ----------------------------------------------------------------------
// core register reset values
// ----------------------------------------------------------------------
`define RCS_INT_CONTROL_MAIN_RST 8'h00
`define RCS_INT_CONTROL_SECOND_RST 8'hff
`define RCS_INT_CONTROL_THIRD_RST 8'hc0
`define RCS_BSR_RST 4'h0

`endif

// file: src/rcs_pkg.sv
package rcs_pkg;

  typedef enum logic [1:0] {
    RCS_PM_FULL,
    RCS_PM_RUN,
    RCS_PM_IDLE
  } rcs_pm_t;

  typedef enum logic [3:0] {
    RCS_ACT_NONE,
    RCS_ACT_POR,
    RCS_ACT_BOR,
    RCS_ACT_DSW,
    RCS_ACT_CM,
    RCS_ACT_RI,
    RCS_ACT_PIN,
    RCS_ACT_SFUL,
    RCS_ACT_SUNF,
    RCS_ACT_WDT,
    RCS_ACT_INT
  } rcs_act_t;

  typedef struct packed {
    logic [7:0] cause;
    logic stk_full;
    logic stk_unf;
    logic [4:0] sp;
    logic [20:0] tos;
    logic [4:0] prog_counter_latch_upper;
    logic [7:0] prog_counter_latch_high;
    logic [21:0] tblptr;
    logic [7:0] table_latch;
    logic [7:0] int_control_main;
    logic [7:0] int_control_second;
    logic [7:0] int_control_third;
    logic [3:0] bank_select_reg;
    logic restart;
    logic pc_load;
    logic [20:0] pc_val;
  } rcs_state_t;

  typedef struct packed {
    logic [7:0][7:0] mem;
    logic [7:0] rdata;
  } rcs_mem_state_t;

endpackage

// file: src/rcs_retain_mem.sv
`timescale 1ns/100ps
`default_nettype none
`include "rcs_params.svh"

// no reset on purpose: contents are unknown after power-up and survive
// every later reset of the core
module rcs_retain_mem (
  input wire logic ref_clk_i,
  input wire logic we_i,
  input wire logic [`RCS_RETAIN_AW-1:0] waddr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [`RCS_RETAIN_AW-1:0] raddr_i,
  output logic [7:0] rdata_o
);
  import rcs_pkg::*;

  rcs_mem_state_t m_reg;
  rcs_mem_state_t m_next;

  always_comb begin
    m_next = m_reg;
    if (we_i) begin
      m_next.mem[waddr_i] = wdata_i;
    end
    m_next.rdata = m_reg.mem[raddr_i];
  end

  always_ff @(posedge ref_clk_i) begin
    m_reg <= m_next;
  end

  assign rdata_o = m_reg.rdata;

endmodule // rcs_retain_mem

`default_nettype wire

// file: verif/rcs_reset_cause_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "rcs_params.svh"

module rcs_reset_cause_tb;
  import rcs_pkg::*;

  typedef struct {
    int due;
    bit ret;
    bit chk;
    logic [7:0] cause;
    logic [7:0] stk;
    logic rs;
    logic pl;
    logic [20:0] pv;
    logic [20:0] tos;
  } rcs_note_t;

  // ----------------------------------------------------------------------
  // stimulus and outputs
  // ----------------------------------------------------------------------
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [9:0] evs = 10'h000;
  rcs_pm_t pm = RCS_PM_FULL;
  logic sfre = 1'b0, ghi = 1'b0, glo = 1'b0, hp = 1'b0;
  logic [20:0] pc = 21'h000000;
  logic cwe = 1'b0, swe = 1'b0, rwe = 1'b0;
  logic [7:0] cwd = 8'h00, rwd = 8'h00;
  logic [1:0] swd = 2'h0;
  logic [2:0] rwa = 3'h0, rra = 3'h0;
  logic [7:0] cause_o, stk_o, pclh_o, tlat_o, ic0_o, ic1_o, ic2_o, rd_o;
  logic [20:0] tos_o, pv_o;
  logic [4:0] pclu_o;
  logic [21:0] tbl_o;
  logic [3:0] bsr_o;
  logic rs_o, pl_o;

  // model of what software should read back
  logic [7:0] c = `RCS_CAUSE_POR_VAL;
  logic [1:0] f = 2'h0;
  logic [4:0] sp = 5'h00;
  logic [20:0] tos_m = 21'h000000, pv_m = 21'h000000;
  bit pv_ok = 1'b1;
  int seed = 32, cyc = 0, fails = 0, n_tests = 0;
  rcs_note_t q[$];
  rcs_note_t mn;

  initial begin
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  always @(posedge ref_clk_i) cyc <= cyc + 1;

  rcs_reset_cause uut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .por_event_i(evs[0]), .bor_event_i(evs[1]),
    .deep_sleep_wake_i(evs[2]), .config_mismatch_i(evs[3]),
    .reset_instr_i(evs[4]), .external_reset_pin_i(evs[5]),
    .stack_overflow_i(evs[6]), .stack_underflow_i(evs[7]),
    .watchdog_timer_i(evs[8]), .int_wake_i(evs[9]),
    .int_high_prio_i(hp), .pm_mode_i(pm),
    .stack_fault_reset_enable_i(sfre),
    .high_prio_global_int_enable_i(ghi),
    .low_prio_global_int_enable_i(glo), .pc_i(pc),
    .cause_we_i(cwe), .cause_wdata_i(cwd),
    .stack_flags_we_i(swe), .stack_flags_wdata_i(swd),
    .retain_we_i(rwe), .retain_waddr_i(rwa), .retain_wdata_i(rwd),
    .retain_raddr_i(rra), .reset_cause_register_o(cause_o),
    .stack_pointer_reg_o(stk_o), .top_of_stack_o(tos_o),
    .prog_counter_latch_upper_o(pclu_o),
    .prog_counter_latch_high_o(pclh_o), .table_pointer_o(tbl_o),
    .table_latch_o(tlat_o), .int_control_main_o(ic0_o),
    .int_control_second_o(ic1_o), .int_control_third_o(ic2_o),
    .bank_select_reg_o(bsr_o), .core_restart_o(rs_o),
    .pc_load_o(pl_o), .pc_load_value_o(pv_o), .retain_rdata_o(rd_o)
  );

  // ----------------------------------------------------------------------
  // checking
  // ----------------------------------------------------------------------
  task automatic cmp(input string nm, input logic [127:0] e,
                     input logic [127:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic note(input int dly, input bit ret, input bit chk,
                      input logic rs, input logic pl, input logic [7:0] rd);
    rcs_note_t n;
    n.due = cyc + dly;
    n.ret = ret;
    n.chk = chk & pv_ok;
    n.rs = rs;
    n.pl = pl;
    n.cause = ret ? rd : c;
    n.stk = {f, 1'b0, sp};
    n.pv = pv_m;
    n.tos = tos_m;
    q.push_back(n);
  endtask

  // outputs are settled by the falling edge, so compare there
  always @(negedge ref_clk_i) begin
    while (q.size() > 0 && q[0].due <= cyc) begin
      mn = q.pop_front();
      if (mn.ret) begin
        cmp("retain data", mn.cause, rd_o);
      end else begin
        cmp("cause", mn.cause, cause_o);
        cmp("cause", mn.cause, cause_o);
        cmp("stack reg", mn.stk, stk_o);
        cmp("restart", mn.rs, rs_o);
        cmp("top of stack", mn.tos, tos_o);
        cmp("fixed regs", {`RCS_INT_CONTROL_MAIN_RST, `RCS_INT_CONTROL_SECOND_RST,
            `RCS_INT_CONTROL_THIRD_RST, `RCS_BSR_RST, 5'h00, 8'h00, 8'h00,
            22'h000000}, {ic0_o, ic1_o, ic2_o, bsr_o, pclu_o, pclh_o,
            tlat_o, tbl_o});
        if (mn.chk) begin
          cmp("pc load", mn.pl, pl_o);
          cmp("pc value", mn.pv, pv_o);
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // drivers
  // ----------------------------------------------------------------------
  task automatic setf();
    cwe = 1'b1;
    cwd = 8'($random(seed));
    swe = 1'b1;
    swd = 2'($random(seed));
    c = cwd & `RCS_CAUSE_MASK;
    f = swd;
    note(1, 0, 1, 1'b0, 1'b0, 8'h00);
    @(negedge ref_clk_i);
    cwe = 1'b0;
    swe = 1'b0;
    @(negedge ref_clk_i);
  endtask

  task automatic ev(input rcs_act_t k, input rcs_pm_t m, input logic en,
                    input logic [9:0] ex);
    logic rs;
    logic pl;
    rs = 1'b0;
    pl = 1'b0;
    pm = m;
    sfre = en;
    pc = 21'($random(seed)) & 21'h0ffffe;
    // lower priority extras must be dropped by the design
    evs = (10'h001 << (int'(k) - 1)) | ex;
    case (k)
      RCS_ACT_POR, RCS_ACT_DSW: begin
        c = `RCS_CAUSE_POR_VAL;
        f = 2'b00;
        rs = 1'b1;
      end
      RCS_ACT_BOR: begin
        c = {2'b00, 4'hf, c[1], 1'b0};
        rs = 1'b1;
      end
      RCS_ACT_CM: begin
        c[5] = 1'b0;
        rs = 1'b1;
      end
      RCS_ACT_RI: begin
        c[4] = 1'b0;
        rs = 1'b1;
      end
      RCS_ACT_PIN: begin
        if (m != RCS_PM_FULL) c[3] = 1'b1;
        if (m == RCS_PM_IDLE) c[2] = 1'b0;
        rs = 1'b1;
      end
      RCS_ACT_SFUL: begin
        f[1] = 1'b1;
        rs = en;
      end
      RCS_ACT_SUNF: begin
        f[0] = 1'b1;
        rs = en;
      end
      RCS_ACT_WDT: begin
        c[3] = 1'b0;
        if (m == RCS_PM_IDLE) begin
          c[2] = 1'b0;
          pl = 1'b1;
          pv_m = pc + `RCS_PC_STEP;
        end else begin
          rs = 1'b1;
        end
      end
      RCS_ACT_INT: begin
        c[2] = 1'b0;
        pl = 1'b1;
        if (ghi | glo) begin
          tos_m = pc + `RCS_PC_STEP;
          sp = sp + 5'h01;
          pv_m = hp ? `RCS_VEC_HIGH : `RCS_VEC_LOW;
        end else begin
          pv_m = pc + `RCS_PC_STEP;
        end
      end
      default: ;
    endcase
    if (rs) begin
      pl = 1'b1;
      pv_m = `RCS_RESET_VECTOR;
      sp = 5'h00;
      tos_m = 21'h000000;
      c[7] = 1'b0;
    end
    // a stack error without restart leaves the pc load unspecified
    pv_ok = en || !(k inside {RCS_ACT_SFUL, RCS_ACT_SUNF});
    note(1, 0, 1, rs, pl, 8'h00);
    @(negedge ref_clk_i);
    evs = 10'h000;
    note(3, 0, 1, 1'b0, 1'b0, 8'h00);
    repeat (4) @(negedge ref_clk_i);
    $display("test %s done", k.name());
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (16) @(negedge ref_clk_i);
    rst_i = 1'b0;
    note(1, 0, 1, 1'b0, 1'b0, 8'h00);
    repeat (2) @(negedge ref_clk_i);
    $display("test reset done");
    for (int ki = 1; ki <= 10; ki++) begin
      for (int mi = 0; mi < 3; mi++) begin
        for (int ei = 0; ei < 2; ei++) begin
          ghi = 1'(ei);
          glo = (mi == 1);
          hp = (mi == 2);
          setf();
          ev(rcs_act_t'(ki), (ki == 10) ? RCS_PM_IDLE : rcs_pm_t'(mi),
             1'(ei), 10'h000);
        end
      end
    end
    setf();
    ev(RCS_ACT_CM, RCS_PM_FULL, 1'b1, 10'h010);
    rwe = 1'b1;
    rwa = 3'($random(seed));
    rwd = 8'($random(seed));
    rra = rwa;
    note(2, 1, 0, 1'b0, 1'b0, rwd);
    @(negedge ref_clk_i);
    rwe = 1'b0;
    @(negedge ref_clk_i);
    ev(RCS_ACT_PIN, RCS_PM_RUN, 1'b1, 10'h000);
    note(1, 1, 0, 1'b0, 1'b0, rwd);
    repeat (3) @(negedge ref_clk_i);
    $display("test retain done");
    end_sim();
  end

  initial begin
    #(50 * 3000);
    fails++;
    $display("ERROR watchdog expected finish seen timeout");
    end_sim();
  end
endmodule // rcs_reset_cause_tb

`default_nettype wire
